// ==== rsd_defs.svh ====
// address map constants for the register space decoder
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH
`define RSD_ADDR_W        12
`define RSD_PADDR_W       16
`define RSD_CTRL_BASE     12'hf00
`define RSD_RAM_BASE      12'h000
`define RSD_RAM1K_TOP     12'h3ff
`define RSD_RAM2K_TOP     12'h7ff
`define RSD_PRAM1K_BASE   12'h400
`define RSD_PRAM1K_TOP    12'h7ff
`define RSD_PRAM2K_BASE   12'h800
`define RSD_PRAM2K_TOP    12'hbff
`define RSD_PRAM_PBASE    16'he000
`define RSD_PRAM_PTOP     16'he3ff
`define RSD_PRAM_AW       10
`define RSD_RAM_AW        11
`define RSD_UNMAP_DATA    8'hff
`define RSD_PROG_UNMAP    8'hff
`endif

// ==== rsd_pkg.sv ====
// types for the register space decoder
package rsd_pkg;
   typedef enum logic [3:0] {
      RSD_T_RAM  = 4'b0001,
      RSD_T_PRAM = 4'b0010,
      RSD_T_CTRL = 4'b0100,
      RSD_T_HOLE = 4'b1000
   } rsd_target_t;
endpackage

// ==== rsd_ram.sv ====
// single port byte ram with registered read data
`timescale 1ns/1ps
module rsd_ram #(
   parameter int AW = 10
) (
   // clock
   input  wire logic          clock,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1<<AW)-1];
   // contents are undefined after reset, as for any register ram
   always_ff @(posedge clock) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ==== rsd_decoder.sv ====
// register space decoder with general ram, remappable program ram, control region
`timescale 1ns/1ps
`include "rsd_defs.svh"
module rsd_decoder #(
   parameter bit RAM_2K = 1'b1
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // mode
   input  wire logic        program_ram_remap_select,
   // register space access from the core
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // control region port to peripherals
   output logic             ctrl_rd,
   output logic             ctrl_wr,
   output logic      [7:0]  ctrl_addr,
   output logic      [7:0]  ctrl_wdata,
   input  wire logic [7:0]  ctrl_rdata,
   // program memory access to program ram window
   input  wire logic        prog_rd,
   input  wire logic        prog_wr,
   input  wire logic [15:0] prog_addr,
   input  wire logic [7:0]  prog_wdata,
   output logic      [7:0]  prog_rdata,
   output logic             prog_rvalid,
   output logic             prog_hit,
   // data-only memory space, unused
   output logic             data_rd,
   output logic             data_wr
);
   // ****************************************************
   // address decode
   // ****************************************************
   function automatic rsd_pkg::rsd_target_t decode(input logic [11:0] a, input logic remap,
                                                   input logic big);
      logic [11:0] ram_top;
      logic [11:0] pb;
      logic [11:0] pt;
      ram_top = big ? `RSD_RAM2K_TOP : `RSD_RAM1K_TOP;
      pb      = big ? `RSD_PRAM2K_BASE : `RSD_PRAM1K_BASE;
      pt      = big ? `RSD_PRAM2K_TOP : `RSD_PRAM1K_TOP;
      if (a >= `RSD_CTRL_BASE) begin
         decode = rsd_pkg::RSD_T_CTRL;
      end else if (a <= ram_top) begin
         decode = rsd_pkg::RSD_T_RAM;
      end else if (remap && a >= pb && a <= pt) begin
         decode = rsd_pkg::RSD_T_PRAM;
      end else begin
         decode = rsd_pkg::RSD_T_HOLE;
      end
   endfunction

   localparam int RAW = RAM_2K ? `RSD_RAM_AW : `RSD_RAM_AW - 1;
   // window bounds for the checks, fixed by the build-time ram size
   localparam logic [11:0] RAM_TOP  = RAM_2K ? `RSD_RAM2K_TOP : `RSD_RAM1K_TOP;
   localparam logic [11:0] PRAM_BOT = RAM_2K ? `RSD_PRAM2K_BASE : `RSD_PRAM1K_BASE;
   localparam logic [11:0] PRAM_TOP = RAM_2K ? `RSD_PRAM2K_TOP : `RSD_PRAM1K_TOP;

   rsd_pkg::rsd_target_t tgt;
   logic                 prog_in_win;
   logic                 prog_ok;
   logic                 reg_pram_acc;
   logic                 reg_rd_acc;

   assign tgt          = decode(reg_addr, program_ram_remap_select, RAM_2K);
   assign prog_in_win  = prog_addr >= `RSD_PRAM_PBASE && prog_addr <= `RSD_PRAM_PTOP;
   // once remapped, the program view is cut off so the two never alias
   assign prog_ok      = prog_in_win && !program_ram_remap_select;
   assign prog_hit     = prog_ok;
   assign reg_pram_acc = (reg_rd || reg_wr) && tgt == rsd_pkg::RSD_T_PRAM;
   assign reg_rd_acc   = reg_rd && !reg_wr;

   // ****************************************************
   // storage
   // ****************************************************
   logic             gram_we;
   logic [RAW-1:0]   gram_addr;
   logic [7:0]       gram_q;
   logic             pram_we;
   logic [9:0]       pram_addr;
   logic [7:0]       pram_wd;
   logic [7:0]       pram_q;

   assign gram_we   = reg_wr && tgt == rsd_pkg::RSD_T_RAM;
   assign gram_addr = reg_addr[RAW-1:0];
   assign pram_we   = reg_pram_acc ? reg_wr : (prog_ok && prog_wr);
   assign pram_addr = reg_pram_acc ? reg_addr[9:0] : prog_addr[9:0];
   assign pram_wd   = reg_pram_acc ? reg_wdata : prog_wdata;

   rsd_ram #(.AW(RAW)) u_gram (
      .clock (clock),
      .we    (gram_we),
      .addr  (gram_addr),
      .wdata (reg_wdata),
      .rdata (gram_q)
   );

   rsd_ram #(.AW(`RSD_PRAM_AW)) u_pram (
      .clock (clock),
      .we    (pram_we),
      .addr  (pram_addr),
      .wdata (pram_wd),
      .rdata (pram_q)
   );

   // ****************************************************
   // control region pass-through
   // ****************************************************
   // unassigned control addresses are left to the peripherals; whatever comes back is returned
   assign ctrl_rd    = reg_rd_acc && tgt == rsd_pkg::RSD_T_CTRL;
   assign ctrl_wr    = reg_wr && tgt == rsd_pkg::RSD_T_CTRL;
   assign ctrl_addr  = reg_addr[7:0];
   assign ctrl_wdata = reg_wdata;
   assign data_rd    = 1'b0;
   assign data_wr    = 1'b0;

   // ****************************************************
   // read return
   // ****************************************************
   rsd_pkg::rsd_target_t rtgt, next_rtgt;
   logic                 rv, next_rv;
   logic                 prv, next_prv;
   logic                 pown, next_pown;
   logic [7:0]           ctrl_q, next_ctrl_q;

   always_comb begin
      next_rtgt   = reg_rd_acc ? tgt : rtgt;
      next_rv     = reg_rd_acc;
      next_ctrl_q = ctrl_rd ? ctrl_rdata : ctrl_q;
      // register side has priority on the shared program ram port
      next_prv    = prog_rd && prog_in_win == 1'b1 && !(reg_pram_acc && prog_ok) || 
                    (prog_rd && !prog_ok);
      next_pown   = prog_ok && !reg_pram_acc;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rtgt   <= rsd_pkg::RSD_T_HOLE;
         rv     <= 1'b0;
         prv    <= 1'b0;
         pown   <= 1'b0;
         ctrl_q <= 8'h00;
      end else begin
         rtgt   <= next_rtgt;
         rv     <= next_rv;
         prv    <= next_prv;
         pown   <= next_pown;
         ctrl_q <= next_ctrl_q;
      end
   end

   always_comb begin
      case (rtgt)
         rsd_pkg::RSD_T_RAM:  reg_rdata = gram_q;
         rsd_pkg::RSD_T_PRAM: reg_rdata = pram_q;
         rsd_pkg::RSD_T_CTRL: reg_rdata = ctrl_q;
         default:             reg_rdata = `RSD_UNMAP_DATA;
      endcase
   end
   assign reg_rvalid  = rv;
   assign prog_rvalid = prv;
   assign prog_rdata  = pown ? pram_q : `RSD_PROG_UNMAP;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_ctrl_read;
      reg_rd && !reg_wr && reg_addr >= `RSD_CTRL_BASE;
   endsequence

   sequence s_ram_read;
      reg_rd && !reg_wr && tgt == rsd_pkg::RSD_T_RAM;
   endsequence

   sequence s_pram_read;
      reg_rd && !reg_wr && tgt == rsd_pkg::RSD_T_PRAM;
   endsequence

   sequence s_prog_miss;
      prog_rd && !prog_ok;
   endsequence

   // control region routing
   ctrl_region_a: assert property (
      s_ctrl_read |-> ctrl_rd && !gram_we)
      else $error("control read not routed to control port");
   ctrl_ret_a: assert property (
      s_ctrl_read ##1 1'b1 |-> reg_rvalid && reg_rdata == $past(ctrl_rdata))
      else $error("control read data mismatch");
   ctrl_quiet_a: assert property (
      reg_addr < `RSD_CTRL_BASE |-> !ctrl_rd && !ctrl_wr)
      else $error("control strobe outside control region");
   ctrl_wr_a: assert property (
      reg_wr && reg_addr >= `RSD_CTRL_BASE |-> ctrl_wr && ctrl_wdata == reg_wdata && !gram_we)
      else $error("control write not routed to control port");
   ctrl_addr_a: assert property (
      ctrl_rd || ctrl_wr |-> ctrl_addr == reg_addr[7:0])
      else $error("control address wrong");
   decode_ctrl_a: assert property (
      reg_addr >= `RSD_CTRL_BASE |-> tgt == rsd_pkg::RSD_T_CTRL)
      else $error("control region decoded wrong");

   // general ram and holes
   low_ram_a: assert property (
      reg_wr && reg_addr < 12'h400 |-> gram_we && !ctrl_wr)
      else $error("low address write missed general ram");
   ram_size_a: assert property (
      reg_addr <= RAM_TOP |-> tgt == rsd_pkg::RSD_T_RAM)
      else $error("general ram size decoded wrong");
   ram_ret_a: assert property (
      s_ram_read |=> reg_rvalid && reg_rdata == gram_q)
      else $error("general ram read data not returned");
   hole_sel_a: assert property (
      tgt == rsd_pkg::RSD_T_HOLE |-> reg_addr > RAM_TOP && reg_addr < `RSD_CTRL_BASE)
      else $error("hole decoded outside the hole range");
   hole_wr_a: assert property (
      reg_wr && tgt == rsd_pkg::RSD_T_HOLE |-> !gram_we && !pram_we && !ctrl_wr)
      else $error("hole write changed state");
   hole_rd_a: assert property (
      reg_rd && !reg_wr && tgt == rsd_pkg::RSD_T_HOLE |=> reg_rvalid && reg_rdata == `RSD_UNMAP_DATA)
      else $error("hole read data wrong");

   // program ram in either view
   no_remap_a: assert property (
      !program_ram_remap_select |-> tgt != rsd_pkg::RSD_T_PRAM)
      else $error("program ram seen in register space without remap");
   remap_win_a: assert property (
      program_ram_remap_select && reg_wr && reg_addr >= PRAM_BOT && reg_addr <= PRAM_TOP
      |-> pram_we)
      else $error("remapped window write missed program ram");
   pram_bound_a: assert property (
      tgt == rsd_pkg::RSD_T_PRAM |-> reg_addr >= PRAM_BOT && reg_addr <= PRAM_TOP)
      else $error("program ram decoded outside its window");
   pram_addr_a: assert property (
      reg_pram_acc |-> pram_addr == reg_addr[9:0] && pram_we == reg_wr)
      else $error("remapped access not steered to program ram");
   pram_ret_a: assert property (
      s_pram_read |=> reg_rvalid && reg_rdata == pram_q)
      else $error("remapped read data not returned");
   prog_win_a: assert property (
      !program_ram_remap_select && prog_addr >= `RSD_PRAM_PBASE && prog_addr <= `RSD_PRAM_PTOP
      |-> prog_hit)
      else $error("program window not served");
   prog_wr_a: assert property (
      prog_ok && prog_wr && !reg_pram_acc |-> pram_we && pram_addr == prog_addr[9:0])
      else $error("program write missed program ram");
   prog_rv_a: assert property (
      prog_rd |=> prog_rvalid)
      else $error("program read not answered next cycle");
   prv_pulse_a: assert property (
      !prog_rd |=> !prog_rvalid)
      else $error("program read valid without a read");
   prog_hit_a: assert property (
      prog_hit |-> !program_ram_remap_select && prog_addr >= `RSD_PRAM_PBASE
      && prog_addr <= `RSD_PRAM_PTOP)
      else $error("program hit outside its window");
   alias_cut_a: assert property (
      program_ram_remap_select |-> !prog_hit ##1 !pown)
      else $error("program view active while remapped");
   prog_cut_a: assert property (
      program_ram_remap_select && prog_wr && !reg_pram_acc |-> !pram_we)
      else $error("program write landed while remapped");
   prog_miss_a: assert property (
      s_prog_miss |=> prog_rdata == `RSD_PROG_UNMAP)
      else $error("program read outside window not ff");

   // access sequencing
   data_idle_a: assert property (
      !data_rd && !data_wr)
      else $error("data space accessed");
   rd_valid_a: assert property (
      reg_rd && !reg_wr |=> reg_rvalid)
      else $error("read not answered next cycle");
   rv_pulse_a: assert property (
      !(reg_rd && !reg_wr) |=> !reg_rvalid)
      else $error("read valid without a read");
   wr_prio_a: assert property (
      reg_rd && reg_wr |-> !ctrl_rd ##1 !reg_rvalid)
      else $error("write with read strobe treated as read");
   // reset must be seen even though the default disable masks it
   reset_idle_a: assert property (
      @(posedge clock) disable iff (1'b0)
      !resetn |=> !reg_rvalid && !prog_rvalid && reg_rdata == `RSD_UNMAP_DATA)
      else $error("outputs not idle after reset");
endmodule

// ==== rsd_periph_model.sv ====
// peripheral model answering the control region port of the decoder
`timescale 1ns/1ps
module rsd_periph_model (
   // clock
   input  wire logic       clock,
   // control port
   input  wire logic       ctrl_rd,
   input  wire logic [7:0] ctrl_addr,
   output logic      [7:0] ctrl_rdata
);
   // ************
   // read answer
   // ************
   logic [7:0] last = 8'h00;
   // idle bus toggles so a stale sample never passes for an answer
   always_comb ctrl_rdata = ctrl_rd ? (ctrl_addr ^ 8'h5a) : ~last;
   always_ff @(posedge clock) last <= ctrl_rdata;
endmodule

// ==== register_space_decoder_tb.sv ====
// self-checking bench for the register space decoder
`timescale 1ns/1ps
module register_space_decoder_tb;
   // ************
   // bench
   // ************
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        program_ram_remap_select = 1'b0;
   logic        reg_rd = 1'b0, reg_wr = 1'b0, prog_rd = 1'b0, prog_wr = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] prog_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, prog_wdata = 8'h00;
   logic [7:0]  reg_rdata, ctrl_addr, ctrl_wdata, ctrl_rdata, prog_rdata;
   logic        reg_rvalid, ctrl_rd, ctrl_wr, prog_rvalid, prog_hit, data_rd, data_wr;
   logic [7:0]  mem [4096];
   logic [7:0]  pmem [1024];
   logic [7:0]  rq [$];
   logic [7:0]  pq [$];
   logic [11:0] a [16];
   logic [11:0] holes [4] = '{12'h800, 12'hbff, 12'hc00, 12'heff};
   logic [11:0] ctls [3] = '{12'hf00, 12'hf7f, 12'hfff};
   int          n_errors = 0, checks_done = 0, cycles = 0, seed = 13, i;
   always #4 clock = ~clock;
   rsd_decoder #(.RAM_2K(1'b1)) dut (.clock(clock), .resetn(resetn),
      .program_ram_remap_select(program_ram_remap_select), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .ctrl_rd(ctrl_rd), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
      .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .prog_rd(prog_rd), .prog_wr(prog_wr),
      .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
      .prog_rvalid(prog_rvalid), .prog_hit(prog_hit), .data_rd(data_rd), .data_wr(data_wr));
   rsd_periph_model pm (.clock(clock), .ctrl_rd(ctrl_rd), .ctrl_addr(ctrl_addr),
      .ctrl_rdata(ctrl_rdata));
   task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one access per call, so calls run back to back every cycle
   task automatic reg_acc(input logic wr, input logic [11:0] ad, input logic [7:0] d);
      logic ctl, ok;
      @(posedge clock);
      ctl = ad >= 12'hf00;
      ok = ad <= 12'h7ff || (program_ram_remap_select && ad >= 12'h800 && ad <= 12'hbff);
      reg_rd <= !wr;
      reg_wr <= wr;
      reg_addr <= ad;
      reg_wdata <= d;
      prog_rd <= 1'b0;
      prog_wr <= 1'b0;
      if (wr && ok) mem[ad] = d;
      if (!wr) rq.push_back(ctl ? ad[7:0] ^ 8'h5a : ok ? mem[ad] : 8'hff);
      #1;
      cmp("ctrl_rd", 16'(ctl && !wr), 16'(ctrl_rd));
      cmp("ctrl_wr", 16'(ctl && wr), 16'(ctrl_wr));
      if (ctl) cmp("ctrl_addr", {ad[7:0], d}, {ctrl_addr, ctrl_wdata});
   endtask
   task automatic prog_acc(input logic wr, input logic [15:0] ad, input logic [7:0] d);
      logic hit;
      @(posedge clock);
      hit = ad >= 16'he000 && ad <= 16'he3ff && !program_ram_remap_select;
      prog_rd <= !wr;
      prog_wr <= wr;
      prog_addr <= ad;
      prog_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      if (wr && hit) pmem[ad[9:0]] = d;
      if (!wr) pq.push_back(hit ? pmem[ad[9:0]] : 8'hff);
      #1;
      cmp("prog_hit", 16'(hit), 16'(prog_hit));
   endtask
   task automatic fin(input string name);
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      prog_rd <= 1'b0;
      prog_wr <= 1'b0;
      repeat (3) @(posedge clock);
      $display("test %s done", name);
   endtask
   // mid-cycle sampling keeps clear of the edge that launches the answer
   always @(negedge clock) begin
      cycles++;
      if (resetn === 1'b1) begin
         cmp("data space", 16'h0000, 16'({data_rd, data_wr}));
         if (reg_rvalid === 1'b1)
            cmp("reg_rdata", rq.size() ? rq.pop_front() : 'x, reg_rdata);
         if (prog_rvalid === 1'b1)
            cmp("prog_rdata", pq.size() ? pq.pop_front() : 'x, prog_rdata);
      end
      if (cycles > 2000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      reg_acc(1'b1, 12'h000, 8'h3c);
      reg_acc(1'b1, 12'h7ff, 8'hc3);
      for (i = 0; i < 16; i++) begin
         a[i] = {1'b0, 11'($random(seed))};
         reg_acc(1'b1, a[i], 8'($random(seed)));
      end
      reg_acc(1'b0, 12'h000, 8'h00);
      reg_acc(1'b0, 12'h7ff, 8'h00);
      for (i = 0; i < 16; i++) reg_acc(1'b0, a[i], 8'h00);
      fin("general ram");
      foreach (holes[j]) begin
         reg_acc(1'b1, holes[j], 8'h11);
         reg_acc(1'b0, holes[j], 8'h00);
      end
      fin("holes");
      program_ram_remap_select <= 1'b1;
      @(posedge clock);
      for (i = 0; i < 16; i++) begin
         a[i] = 12'h800 | {2'b00, 10'($random(seed))};
         reg_acc(1'b1, a[i], 8'($random(seed)));
      end
      for (i = 0; i < 16; i++) reg_acc(1'b0, a[i], 8'h00);
      reg_acc(1'b0, 12'h7ff, 8'h00);
      reg_acc(1'b0, 12'hc00, 8'h00);
      prog_acc(1'b1, 16'he001, 8'h55);
      prog_acc(1'b0, 16'he001, 8'h00);
      fin("remap");
      program_ram_remap_select <= 1'b0;
      @(posedge clock);
      prog_acc(1'b1, 16'he000, 8'ha5);
      prog_acc(1'b1, 16'he3ff, 8'h5a);
      prog_acc(1'b0, 16'he000, 8'h00);
      prog_acc(1'b0, 16'he3ff, 8'h00);
      prog_acc(1'b0, 16'he400, 8'h00);
      reg_acc(1'b0, 12'h800, 8'h00);
      fin("program ram");
      foreach (ctls[j]) begin
         reg_acc(1'b1, ctls[j], 8'($random(seed)));
         reg_acc(1'b0, ctls[j], 8'h00);
      end
      reg_acc(1'b0, 12'h000, 8'h00);
      fin("control");
      cmp("queues left", 16'h0000, 16'(rq.size() + pq.size()));
      report_and_stop();
   end
endmodule
